/* File: design/sfcp_regs.vh */
// Opcodes, status bit positions and timing counts of the command block
`ifndef SFCP_REGS_VH
`define SFCP_REGS_VH

// ****************************************
// Opcodes
// ****************************************
`define SFCP_OP_WR_EN    8'h06
`define SFCP_OP_WR_DIS   8'h04
`define SFCP_OP_STAT     8'h05
`define SFCP_OP_SECR     8'h2B
`define SFCP_OP_CONT     8'hAD
`define SFCP_OP_PAR_IN   8'h55
`define SFCP_OP_PAR_OUT  8'h45
`define SFCP_OP_SLEEP    8'hB9
`define SFCP_OP_SIG      8'hAB
`define SFCP_OP_IDENT    8'h9F
`define SFCP_OP_MAKER    8'h90
`define SFCP_OP_READ     8'h03
`define SFCP_OP_PAGE     8'h02

// ****************************************
// Status and security bit positions
// ****************************************
`define SFCP_ST_BUSY_BIT 0
`define SFCP_ST_LATCH_BIT 1
`define SFCP_SEC_CONT_BIT 4

// ****************************************
// Timing
// ****************************************
`define SFCP_CLK_MHZ     25
`define SFCP_T_PROG_NS   10000
`define SFCP_T_ENTRY_NS  10000
`define SFCP_T_WAKE_NS   10000
// Program and wake are longest times: round down
`define SFCP_PROG_CYC  ((`SFCP_T_PROG_NS * `SFCP_CLK_MHZ) / 1000)
`define SFCP_WAKE_CYC  ((`SFCP_T_WAKE_NS * `SFCP_CLK_MHZ) / 1000)
// Entry delay is a least time: round up
`define SFCP_ENTRY_CYC ((`SFCP_T_ENTRY_NS * `SFCP_CLK_MHZ + 999) / 1000)

`endif

/* File: design/sfcp_sync.v */
// Two-flop synchroniser, one chain per bit
`timescale 1ns/100ps
module sfcp_sync #(
	parameter WIDTH = 3
) (
	input  wire             clk_sys_in, // System clock
	input  wire             rst_in,     // Async reset, high
	input  wire [WIDTH-1:0] async_in,   // Foreign-domain levels
	output wire [WIDTH-1:0] sync_out    // Synchronised levels
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			reg meta;
			reg stable;
			always @(posedge clk_sys_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					meta   <= 1'b0;
					stable <= 1'b0;
				end
				else
				begin
					meta   <= async_in[i];
					stable <= meta;
				end
			end
			assign sync_out[i] = stable;
		end
	endgenerate
endmodule // sfcp_sync

/* File: design/sfcp_buf.v */
// Two-entry valid/ready buffer for program requests
`timescale 1ns/100ps
module sfcp_buf #(
	parameter WIDTH = 40
) (
	input  wire             clk_sys_in, // System clock
	input  wire             rst_in,     // Async reset, high
	input  wire             in_valid_in, // Source has a word
	output wire             in_ready_out, // Space available
	input  wire [WIDTH-1:0] in_data_in, // Word in
	output wire             out_valid_out, // Word available
	input  wire             out_ready_in, // Sink takes word
	output wire [WIDTH-1:0] out_data_out // Word out
);
	reg [WIDTH-1:0] mem [0:1];
	reg             wr_ptr;
	reg             rd_ptr;
	reg [1:0]       count;
	wire            do_wr = in_valid_in & (count != 2'h2);
	wire            do_rd = out_ready_in & (count != 2'h0);

	assign in_ready_out  = (count != 2'h2);
	assign out_valid_out = (count != 2'h0);
	assign out_data_out  = mem[rd_ptr];

	always @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mem[0] <= {WIDTH{1'b0}};
			mem[1] <= {WIDTH{1'b0}};
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end
		else
		begin
			if (do_wr)
			begin
				mem[wr_ptr] <= in_data_in;
				wr_ptr      <= ~wr_ptr;
			end
			if (do_rd)
				rd_ptr <= ~rd_ptr;
			if (do_wr & ~do_rd)
				count <= count + 2'h1;
			else if (do_rd & ~do_wr)
				count <= count - 2'h1;
		end
	end
endmodule // sfcp_buf

/* File: design/sfcp_top.v */
// Serial flash command block: pair programming, parallel mode, sleep
`timescale 1ns/100ps
`include "sfcp_regs.vh"

// What this block does
// - Opcode, three address bytes, two data bytes: even then odd address.
// - One data byte programs nothing; bytes beyond two are ignored.
// - No address wrap; past last unprotected address leave mode, clear flags.
// - In pair-program mode only pair, disable, status, security reads pass.
// - Disable in pair-program mode only takes effect when not busy.
// - Later pairs: opcode plus two bytes; disable ends; security bit4 shows.
// - Protected target: array untouched, write latch still cleared.
// - After parallel entry and select rise, only listed commands accepted.
// - Parallel mode left by exit opcode or power cycle.
// - Sleep opcode framed by select; sleep starts after entry delay.
// - Asleep, everything ignored except release and signature read.
// - Release runs only if select rises on a byte boundary after the opcode.
// - Select rise after release: awake immediate, asleep after wake delay.
// - Signature byte repeats while clocked; ends on rise after one read.
// - Release and signature read refused while a write cycle runs.
// - After power-up the block is awake, never asleep.
// - Busy flag set for the program cycle, cleared at end; latch stays set in pair mode.
// - Security bit4 reports pair-program mode: 1 active, 0 inactive.
module sfcp_top #(
	parameter [7:0]  SIG_CODE  = 8'h5A, // Arbitrary signature value
	parameter [15:0] PROG_CYC  = `SFCP_PROG_CYC,
	parameter [15:0] ENTRY_CYC = `SFCP_ENTRY_CYC,
	parameter [15:0] WAKE_CYC  = `SFCP_WAKE_CYC
) (
	input  wire        clk_sys_in,     // System clock, 25 MHz
	input  wire        rst_in,         // Power-on reset, high
	input  wire        sclk_in,        // Serial clock pin
	input  wire        cs_n_in,        // Chip select pin, low
	input  wire        si_in,          // Serial data in pin
	output reg         so_out,         // Serial data out
	output reg         so_oe_out,      // Data out drive enable
	input  wire        protect_in,     // Target address protected
	input  wire [23:0] last_addr_in,   // Last unprotected address
	output wire        prog_valid_out, // Program request valid
	input  wire        prog_ready_in,  // Array takes request
	output wire [23:0] prog_addr_out,  // Even start address
	output wire [15:0] prog_data_out,  // Even byte high, odd low
	output reg  [7:0]  cmd_out,        // Opcode for other logic
	output reg         cmd_strobe_out, // Opcode pulse
	output wire        write_latch_flag_out,   // Write latch
	output wire        write_in_progress_out,  // Busy
	output wire        continuous_program_out, // Pair mode on
	output wire        parallel_mode_out,      // 8-bit I/O mode
	output wire        deep_sleep_out          // Asleep
);
	// ****************************************
	// States
	// ****************************************
	localparam [2:0] ST_CMD  = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_DATA = 3'h2;
	localparam [2:0] ST_OUT  = 3'h3;
	localparam [2:0] ST_HOLD = 3'h4;
	localparam [2:0] ST_IGN  = 3'h5;

	// ****************************************
	// Declarations
	// ****************************************
	wire        s_sclk;
	wire        s_cs;
	wire        s_cs_n;
	wire        s_si;
	reg         prev_sclk;
	reg         prev_cs_n;
	reg  [6:0]  shift;
	reg  [2:0]  bit_cnt;
	reg  [2:0]  phase;
	reg  [2:0]  next_phase;
	reg         fwd;
	reg  [7:0]  opcode;
	reg  [1:0]  addr_cnt;
	reg  [1:0]  data_cnt;
	reg  [23:0] addr;
	reg  [7:0]  data0;
	reg  [7:0]  data1;
	reg         write_latch_flag;
	reg         write_in_progress;
	reg         cont_mode;
	reg         par_mode;
	reg         sleep;
	reg         entry_pend;
	reg         wake_pend;
	reg  [15:0] prog_cnt;
	reg  [15:0] pm_cnt;
	reg         push;
	reg  [6:0]  out_shift;
	reg  [2:0]  out_cnt;
	reg  [7:0]  cur_out;
	wire        buf_ready;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        cs_rise;
	wire        cs_fall;
	wire [7:0]  in_byte;
	wire        byte_done;
	wire        dozing;
	wire        boundary;

	// ****************************************
	// Pin sampling
	// ****************************************
	sfcp_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in    (rst_in),
		.async_in  ({sclk_in, ~cs_n_in, si_in}),
		.sync_out  ({s_sclk, s_cs, s_si})
	);

	// Select synced as active high: reset zero is idle, no false edge
	assign s_cs_n    = ~s_cs;
	assign sclk_rise = s_sclk & ~prev_sclk & ~s_cs_n;
	assign sclk_fall = ~s_sclk & prev_sclk & ~s_cs_n;
	assign cs_rise   = s_cs_n & ~prev_cs_n;
	assign cs_fall   = ~s_cs_n & prev_cs_n;
	assign in_byte   = {shift, s_si};
	assign byte_done = sclk_rise & (bit_cnt == 3'h7);
	assign boundary  = (bit_cnt == 3'h0);
	// Entry and wake windows count as asleep
	assign dozing    = sleep | entry_pend | wake_pend;

	assign write_latch_flag_out   = write_latch_flag;
	assign write_in_progress_out  = write_in_progress;
	assign continuous_program_out = cont_mode;
	assign parallel_mode_out      = par_mode;
	assign deep_sleep_out         = sleep;

	// ****************************************
	// Opcode filter
	// ****************************************
	always @*
	begin
		next_phase = ST_IGN;
		fwd        = 1'b0;
		if (dozing)
		begin
			if (in_byte == `SFCP_OP_SIG && !write_in_progress)
				next_phase = ST_OUT;
		end
		else if (cont_mode)
		begin
			case (in_byte)
			`SFCP_OP_CONT:
				if (!write_in_progress && buf_ready)
					next_phase = ST_DATA;
			`SFCP_OP_WR_DIS:
				next_phase = ST_HOLD;
			`SFCP_OP_STAT, `SFCP_OP_SECR:
				next_phase = ST_OUT;
			default:
				next_phase = ST_IGN;
			endcase
		end
		else
		begin
			case (in_byte)
			`SFCP_OP_CONT:
				if (write_latch_flag && !write_in_progress && buf_ready && !par_mode)
					next_phase = ST_ADDR;
			`SFCP_OP_STAT, `SFCP_OP_SECR:
				if (!par_mode)
					next_phase = ST_OUT;
			`SFCP_OP_SIG:
				if (!write_in_progress)
					next_phase = ST_OUT;
			`SFCP_OP_WR_EN, `SFCP_OP_WR_DIS, `SFCP_OP_PAR_OUT:
				next_phase = ST_HOLD;
			`SFCP_OP_PAR_IN, `SFCP_OP_SLEEP:
				if (!par_mode)
					next_phase = ST_HOLD;
			default:
				fwd = !par_mode ||
					in_byte == `SFCP_OP_IDENT ||
					in_byte == `SFCP_OP_MAKER ||
					in_byte == `SFCP_OP_READ ||
					in_byte == `SFCP_OP_PAGE;
			endcase
		end
	end

	// ****************************************
	// Read-back byte
	// ****************************************
	always @*
	begin
		cur_out = 8'h00;
		case (opcode)
		`SFCP_OP_STAT:
		begin
			cur_out[`SFCP_ST_BUSY_BIT]  = write_in_progress;
			cur_out[`SFCP_ST_LATCH_BIT] = write_latch_flag;
		end
		`SFCP_OP_SECR:
			cur_out[`SFCP_SEC_CONT_BIT] = cont_mode;
		default:
			cur_out = SIG_CODE;
		endcase
	end

	// ****************************************
	// Command engine
	// ****************************************
	always @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prev_sclk      <= 1'b0;
			prev_cs_n      <= 1'b1;
			shift          <= 7'h00;
			bit_cnt        <= 3'h0;
			phase          <= ST_CMD;
			opcode         <= 8'h00;
			addr_cnt       <= 2'h0;
			data_cnt       <= 2'h0;
			addr           <= 24'h000000;
			data0          <= 8'h00;
			data1          <= 8'h00;
			write_latch_flag            <= 1'b0;
			write_in_progress            <= 1'b0;
			cont_mode      <= 1'b0;
			par_mode       <= 1'b0;
			sleep          <= 1'b0;
			entry_pend     <= 1'b0;
			wake_pend      <= 1'b0;
			prog_cnt       <= 16'h0000;
			pm_cnt         <= 16'h0000;
			push           <= 1'b0;
			out_shift      <= 7'h00;
			out_cnt        <= 3'h0;
			so_out         <= 1'b0;
			so_oe_out      <= 1'b0;
			cmd_out        <= 8'h00;
			cmd_strobe_out <= 1'b0;
		end
		else
		begin
			prev_sclk      <= s_sclk;
			prev_cs_n      <= s_cs_n;
			push           <= 1'b0;
			cmd_strobe_out <= 1'b0;

			if (sclk_rise)
			begin
				shift   <= in_byte[6:0];
				bit_cnt <= bit_cnt + 3'h1;
			end

			if (byte_done)
			begin
				case (phase)
				ST_CMD:
				begin
					opcode <= in_byte;
					phase  <= next_phase;
					if (fwd)
					begin
						cmd_out        <= in_byte;
						cmd_strobe_out <= 1'b1;
					end
					if (next_phase == ST_OUT)
					begin
						so_oe_out <= 1'b1;
						out_cnt   <= 3'h0;
					end
				end
				ST_ADDR:
				begin
					addr     <= {addr[15:0], in_byte};
					addr_cnt <= addr_cnt + 2'h1;
					if (addr_cnt == 2'h2)
						phase <= ST_DATA;
				end
				ST_DATA:
				begin
					if (data_cnt == 2'h0)
						data0 <= in_byte;
					if (data_cnt == 2'h1)
						data1 <= in_byte;
					if (data_cnt != 2'h2)
						data_cnt <= data_cnt + 2'h1;
				end
				ST_HOLD:
					// One-byte command overrun is rejected
					phase <= ST_IGN;
				default:
					phase <= phase;
				endcase
			end

			if (sclk_fall && phase == ST_OUT)
			begin
				out_cnt <= out_cnt + 3'h1;
				if (out_cnt == 3'h0)
				begin
					// Reload live so busy polling sees changes
					so_out    <= cur_out[7];
					out_shift <= cur_out[6:0];
				end
				else
				begin
					so_out    <= out_shift[6];
					out_shift <= {out_shift[5:0], 1'b0};
				end
			end

			// Program cycle timer
			if (write_in_progress)
			begin
				if (prog_cnt <= 16'h0001)
				begin
					write_in_progress  <= 1'b0;
					addr <= {addr[23:1] + 23'h000001, 1'b0};
					// stop at last address, no wrap
					if (addr[23:1] >= last_addr_in[23:1])
					begin
						cont_mode <= 1'b0;
						write_latch_flag       <= 1'b0;
					end
				end
				else
					prog_cnt <= prog_cnt - 16'h0001;
			end

			if (entry_pend || wake_pend)
			begin
				if (pm_cnt <= 16'h0001)
				begin
					sleep      <= entry_pend;
					entry_pend <= 1'b0;
					wake_pend  <= 1'b0;
				end
				else
					pm_cnt <= pm_cnt - 16'h0001;
			end

			if (cs_rise && boundary)
			begin
				case (phase)
				ST_HOLD:
					case (opcode)
					`SFCP_OP_WR_EN:
						write_latch_flag <= 1'b1;
					`SFCP_OP_WR_DIS:
						if (!write_in_progress)
						begin
							write_latch_flag       <= 1'b0;
							cont_mode <= 1'b0;
						end
					`SFCP_OP_PAR_IN:
						par_mode <= 1'b1;
					`SFCP_OP_PAR_OUT:
						par_mode <= 1'b0;
					`SFCP_OP_SLEEP:
					begin
						entry_pend <= 1'b1;
						pm_cnt     <= ENTRY_CYC;
					end
					default:
						write_latch_flag <= write_latch_flag;
					endcase
				ST_OUT:
					if (opcode == `SFCP_OP_SIG && dozing)
					begin
						sleep      <= 1'b0;
						entry_pend <= 1'b0;
						wake_pend  <= 1'b1;
						pm_cnt     <= WAKE_CYC;
					end
				ST_DATA:
					if (data_cnt == 2'h2 && !write_in_progress)
					begin
						if (protect_in)
						begin
							write_latch_flag       <= 1'b0;
							cont_mode <= 1'b0;
						end
						else if (buf_ready)
						begin
							push      <= 1'b1;
							write_in_progress       <= 1'b1;
							cont_mode <= 1'b1;
							prog_cnt  <= PROG_CYC;
						end
					end
				default:
					write_latch_flag <= write_latch_flag;
				endcase
			end

			if (cs_rise || cs_fall)
			begin
				phase     <= ST_CMD;
				bit_cnt   <= 3'h0;
				addr_cnt  <= 2'h0;
				data_cnt  <= 2'h0;
				so_oe_out <= 1'b0;
				so_out    <= 1'b0;
			end
		end
	end

	// ****************************************
	// Program request buffer
	// ****************************************
	// Two entries let the array stall without losing a pair
	sfcp_buf #(
		.WIDTH(40)
	) u_buf (
		.clk_sys_in   (clk_sys_in),
		.rst_in       (rst_in),
		.in_valid_in  (push),
		.in_ready_out (buf_ready),
		.in_data_in   ({addr[23:1], 1'b0, data0, data1}),
		.out_valid_out(prog_valid_out),
		.out_ready_in (prog_ready_in),
		.out_data_out ({prog_addr_out, prog_data_out})
	);
endmodule // sfcp_top

/* File: dv/sfcp_top_sva.sv */
// Port checks for the serial flash command block
`timescale 1ns/100ps
`include "sfcp_regs.vh"
module sfcp_top_sva #(
	parameter [15:0] PROG_CYC  = 16'h00FA,
	parameter [15:0] ENTRY_CYC = 16'h00FA
) (
	input wire        clk_sys_in,             // System clock
	input wire        rst_in,                 // Async reset, high
	input wire        cs_n_in,                // Chip select pin
	input wire        prog_ready_in,          // Array takes request
	input wire        prog_valid_out,         // Request valid
	input wire [23:0] prog_addr_out,          // Request address
	input wire [15:0] prog_data_out,          // Request data
	input wire [7:0]  cmd_out,                // Forwarded opcode
	input wire        cmd_strobe_out,         // Opcode pulse
	input wire        write_latch_flag_out,   // Write latch
	input wire        write_in_progress_out,  // Busy
	input wire        continuous_program_out, // Pair mode on
	input wire        parallel_mode_out,      // Parallel mode
	input wire        deep_sleep_out          // Asleep
);
	reg [15:0] busy_cnt;
	reg [15:0] cs_hi_cnt;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	// ****
	// Busy run length, select-high time (saturates)
	// ****
	always @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			busy_cnt  <= 16'h0000;
			cs_hi_cnt <= 16'h0000;
		end
		else
		begin
			busy_cnt  <= write_in_progress_out ? busy_cnt + 16'h0001 : 16'h0000;
			cs_hi_cnt <= !cs_n_in ? 16'h0000 :
				(&cs_hi_cnt ? cs_hi_cnt : cs_hi_cnt + 16'h0001);
		end
	end

	sequence s_wake;
		$fell(deep_sleep_out);
	endsequence
	sequence s_stall;
		prog_valid_out && !prog_ready_in;
	endsequence

	AST_BUSY_LEN: assert property (
		$fell(write_in_progress_out) |-> busy_cnt == PROG_CYC)
		else $error("busy length wrong");
	AST_MODE_LATCH: assert property (
		continuous_program_out |-> write_latch_flag_out)
		else $error("pair mode without latch");
	AST_EVEN_ADDR: assert property (
		prog_valid_out |-> !prog_addr_out[0])
		else $error("odd program address");
	AST_HOLD_STALL: assert property (
		s_stall |=> prog_valid_out && $stable(prog_addr_out)
			&& $stable(prog_data_out))
		else $error("stalled request changed");
	AST_SLEEP_MUTE: assert property (
		deep_sleep_out |-> !cmd_strobe_out)
		else $error("opcode forwarded while asleep");
	AST_PAIR_ONLY: assert property (
		continuous_program_out && cmd_strobe_out |-> cmd_out inside
			{`SFCP_OP_CONT, `SFCP_OP_WR_DIS, `SFCP_OP_STAT, `SFCP_OP_SECR})
		else $error("bad opcode in pair mode");
	AST_PAR_ONLY: assert property (
		parallel_mode_out && cmd_strobe_out |-> cmd_out inside
			{`SFCP_OP_IDENT, `SFCP_OP_MAKER, `SFCP_OP_READ, `SFCP_OP_PAGE})
		else $error("bad opcode in parallel mode");
	AST_SLEEP_DELAY: assert property (
		$rose(deep_sleep_out) |-> cs_hi_cnt >= ENTRY_CYC)
		else $error("sleep entered too early");
	AST_WAKE_CS: assert property (
		s_wake |-> cs_n_in && $past(cs_n_in))
		else $error("wake without select high");
	AST_WAKE_IDLE: assert property (
		s_wake |-> !$past(write_in_progress_out))
		else $error("wake during write cycle");
endmodule // sfcp_top_sva

/* File: dv/sfcp_host.sv */
// Behavioural host controller on the serial link
`timescale 1ns/100ps
module sfcp_host (
	output logic sclk_out, // Serial clock
	output logic cs_n_out, // Chip select, low
	output logic si_out,   // Data to block
	input  wire  so_in     // Data from block
);
	logic [7:0] rd;

	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out   = 1'b0;
		rd       = 8'h00;
	end

	// ****
	// One framed transfer, clock idle low outside
	// ****
	// slow clock, framed
	task automatic frame(input logic [7:0] q[$], input int nbits);
		int i;
		cs_n_out = 1'b0;
		#160;
		for (i = 0; i < nbits; i++)
		begin
			si_out = (i / 8 < q.size()) ? q[i / 8][7 - i % 8] : 1'b0;
			#80 sclk_out = 1'b1;
			rd = {rd[6:0], so_in};
			#160 sclk_out = 1'b0;
			#80;
		end
		cs_n_out = 1'b1;
		// Released line must not look stable
		si_out = ~si_out;
		#400;
	endtask
endmodule // sfcp_host

/* File: dv/sfcp_top_tb.sv */
// Self-checking bench for the serial flash command block
`timescale 1ns/100ps
`include "sfcp_regs.vh"
module sfcp_top_tb;
	localparam [15:0] PROG  = 16'h00FA;
	localparam [15:0] SHORT = 16'h0004;
	localparam [7:0]  SIG   = 8'hC3; // Arbitrary signature value
	logic        clk_sys_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        protect    = 1'b0;
	logic        prog_ready = 1'b0;
	logic [23:0] last_addr  = 24'h7FFFFE;
	logic [23:0] addr;
	logic [7:0]  d0, d1;
	logic [39:0] e;
	wire         sclk, cs_n, si, so, so_oe, prog_valid, strobe;
	wire         latch, busy, mode, par, sleep;
	wire  [23:0] prog_addr;
	wire  [15:0] prog_data;
	wire  [7:0]  cmd;
	wire         so_line = so_oe ? so : ~so;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          strobes = 0;
	int          k;
	logic [7:0]  fwd [4] = '{`SFCP_OP_IDENT, `SFCP_OP_MAKER,
		`SFCP_OP_READ, `SFCP_OP_PAGE};

	sfcp_host u_host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si),
		.so_in(so_line));
	sfcp_top #(.SIG_CODE(SIG), .PROG_CYC(PROG), .ENTRY_CYC(SHORT),
		.WAKE_CYC(SHORT)) DUT (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sclk_in(sclk),
		.cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
		.protect_in(protect), .last_addr_in(last_addr),
		.prog_valid_out(prog_valid), .prog_ready_in(prog_ready),
		.prog_addr_out(prog_addr), .prog_data_out(prog_data),
		.cmd_out(cmd), .cmd_strobe_out(strobe),
		.write_latch_flag_out(latch), .write_in_progress_out(busy),
		.continuous_program_out(mode), .parallel_mode_out(par),
		.deep_sleep_out(sleep));

	always #20 clk_sys_in = ~clk_sys_in;

	// Forwarded opcode pulses, counted off the launching edge
	always @(negedge clk_sys_in)
		if (strobe === 1'b1)
			strobes++;

	function automatic logic [39:0] word(input logic [23:0] a,
		input logic [7:0] b0, input logic [7:0] b1);
		return {a & 24'hFFFFFE, b0, b1};
	endfunction
	function automatic logic [7:0] status(input logic write_in_progress, input logic write_latch_flag);
		return {6'h00, write_latch_flag, write_in_progress};
	endfunction

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic send(input logic [7:0] q[$], input int extra);
		@(negedge clk_sys_in);
		u_host.frame(q, q.size() * 8 + extra);
		// Frame ends in the clock's own time step: step past it
		@(negedge clk_sys_in);
	endtask
	task automatic pair_at(input logic [23:0] a, input int n);
		logic [7:0] q[$];
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		q = {`SFCP_OP_CONT, a[23:16], a[15:8], a[7:0], d0, d1, 8'($urandom)};
		send(q[0:3 + n], 0);
	endtask
	task automatic more(input int n, input int extra);
		logic [7:0] q[$];
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		q = {`SFCP_OP_CONT, d0, d1};
		send(q[0:n], extra);
	endtask
	// Program time is fixed, so waiting it out is safe
	task automatic idle;
		repeat (300) @(negedge clk_sys_in);
	endtask

	// ****
	// Scenarios
	// ****
	initial
	begin
		void'($urandom(93416));
		repeat (16) @(negedge clk_sys_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		check({latch, busy, mode, par, sleep}, 40'h0);
		addr = 24'($urandom) & 24'h3FFFFE;
		pair_at(addr, 2);
		check({mode, prog_valid}, 40'h0);
		send({`SFCP_OP_WR_EN}, 0);
		pair_at(addr, 3);
		check({prog_addr, prog_data}, word(addr, d0, d1));
		check({busy, mode, latch}, 40'h7);
		send({`SFCP_OP_STAT, 8'h00}, 0);
		check(u_host.rd & 8'h03, status(1'b1, 1'b1));
		send({`SFCP_OP_SECR, 8'h00}, 0);
		check(u_host.rd[4], 40'h1);
		send({`SFCP_OP_IDENT}, 0);
		check(cmd === `SFCP_OP_IDENT, 40'h0);
		idle;
		check({busy, latch, mode}, 40'h3);
		more(2, 0);
		e = word(addr + 24'h2, d0, d1);
		idle;
		more(2, 0);
		check({busy, prog_addr}, {1'b0, addr});
		prog_ready = 1'b1;
		@(negedge clk_sys_in);
		check({prog_addr, prog_data}, e);
		@(negedge clk_sys_in);
		check(prog_valid, 40'h0);
		more(1, 0);
		check({busy, prog_valid}, 40'h0);
		more(2, 3);
		check({busy, prog_valid}, 40'h0);
		more(2, 0);
		send({`SFCP_OP_WR_DIS}, 0);
		check({mode, busy}, 40'h3);
		idle;
		send({`SFCP_OP_WR_DIS}, 0);
		check({mode, latch}, 40'h0);
		send({`SFCP_OP_SECR, 8'h00}, 0);
		check(u_host.rd[4], 40'h0);
		send({`SFCP_OP_WR_EN}, 0);
		last_addr = 24'($urandom) & 24'h7FFFFE;
		pair_at(last_addr, 2);
		idle;
		check({mode, latch, busy}, 40'h0);
		protect = 1'b1;
		send({`SFCP_OP_WR_EN}, 0);
		pair_at(addr, 2);
		check({latch, mode, busy, prog_valid}, 40'h0);
		protect = 1'b0;
		send({`SFCP_OP_PAR_IN}, 0);
		check(par, 40'h1);
		for (k = 0; k < 4; k++)
		begin
			send({fwd[k]}, 0);
			check(cmd, fwd[k]);
		end
		check(strobes, 40'h4);
		send({`SFCP_OP_SLEEP}, 0);
		check(sleep, 40'h0);
		send({`SFCP_OP_PAR_OUT}, 0);
		check(par, 40'h0);
		send({`SFCP_OP_SLEEP}, 0);
		check(sleep, 40'h1);
		send({`SFCP_OP_WR_EN}, 0);
		check({sleep, latch}, 40'h2);
		send({`SFCP_OP_SIG}, 3);
		check(sleep, 40'h1);
		send({`SFCP_OP_SIG}, 0);
		check(sleep, 40'h0);
		send({`SFCP_OP_SIG, 8'h00, 8'h00}, 0);
		check(u_host.rd, SIG);
		finish_test;
	end

	// Plan needs about 0.24 ms; over twelve times that means a hang
	initial
	begin
		#3000000;
		mismatches++;
		finish_test;
	end
endmodule // sfcp_top_tb

bind sfcp_top sfcp_top_sva #(.PROG_CYC(PROG_CYC), .ENTRY_CYC(ENTRY_CYC)) u_sva (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
	.prog_ready_in(prog_ready_in), .prog_valid_out(prog_valid_out),
	.prog_addr_out(prog_addr_out), .prog_data_out(prog_data_out),
	.cmd_out(cmd_out), .cmd_strobe_out(cmd_strobe_out),
	.write_latch_flag_out(write_latch_flag_out),
	.write_in_progress_out(write_in_progress_out),
	.continuous_program_out(continuous_program_out),
	.parallel_mode_out(parallel_mode_out), .deep_sleep_out(deep_sleep_out));
